// ==== design/ata_sector_write.sv ====
// Sector write and health-monitoring command interpreter, AXI4-Lite task file
//
// Overview of operation
// - 28-bit write count zero means 256
// - Start at task-file address, advance consecutively
// - Accept sets busy, then request, drop busy
// - No interrupt before first sector transfer
// - Full sector, more left: busy, no request
// - Next buffer ready: request plus interrupt
// - After last sector busy until done, interrupt
// - On error stop, report failing address
// - 28-bit drive/head and address byte layout
// - 48-bit count zero means 65536
// - 48-bit write interrupts every request block
// - 48-bit fields take two writes, high first
// - 48-bit error reports full failing address
// - Write-verify follows write sequence, verifies each
// - Decode D0h, D1h, DAh health features
// - Accept D2h, D8h, D9h health features
// - Abort unsupported health feature values
// - High-order byte select reaches high halves
// - Health enable state kept across power
// - Health data read returns one sector
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module ata_sector_write
    import ata_wr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic host_intrq_r,
    output media_req_t media_req_r,
    output logic media_req_valid_r,
    input wire logic media_ack,
    input wire logic media_err,
    output logic [31:0] media_wdata_r,
    output logic media_wvalid_r,
    input wire logic [31:0] smart_word,
    output logic [6:0] smart_index_r,
    input wire logic smart_en_nv,
    output logic smart_en_r
);
    cmd_state_t state_r;
    logic aw_ok_r, w_ok_r, do_wr, do_rd, busy, data_request_flag, tf_wr, tf_rd;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rd_mux;
    logic [3:0] wstrb_r;
    logic [7:0] wb, feature_r, dh_r, devctl_r, error_r;
    logic [7:0] cnt_c, cnt_p, lo_c, lo_p, mid_c, mid_p, hi_c, hi_p;
    logic we_data, we_cnt, we_lo, we_mid, we_hi, we_cmd, rd_data, rd_st;
    logic accept, acc_wr, acc_smart, ext_r, smart_rd_r, init_r;
    logic [47:0] lba_r, lba28, lba48;
    logic [16:0] remain_r;
    logic [6:0] word_r;
    logic last_word, ack_ok, ack_err, smart_ok, ld_err, sect_done;
    logic [1:0] rresp_nxt;

    ////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    assign s_axi_awready = !aw_ok_r;
    assign s_axi_wready = !w_ok_r;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;
    assign do_rd = s_axi_arvalid && s_axi_arready;
    assign wb = wdata_r[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_ok_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (do_wr) begin
                w_ok_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r > OFS_ERROR || awaddr_r[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Task-file writes other than device control and data are ignored while a command runs
    assign tf_wr = do_wr && wstrb_r[0] && !busy && !data_request_flag;
    assign we_data = do_wr && awaddr_r == OFS_DATA && state_r == S_XFER;
    assign we_cnt = tf_wr && awaddr_r == OFS_COUNT;
    assign we_lo = tf_wr && awaddr_r == OFS_ADDR_LO;
    assign we_mid = tf_wr && awaddr_r == OFS_ADDR_MID;
    assign we_hi = tf_wr && awaddr_r == OFS_ADDR_HI;
    assign we_cmd = tf_wr && awaddr_r == OFS_CMD;
    assign rd_data = do_rd && s_axi_araddr == OFS_DATA && state_r == S_SOUT;
    assign rd_st = do_rd && s_axi_araddr == OFS_CMD;
    assign tf_rd = do_rd && s_axi_araddr >= OFS_COUNT && s_axi_araddr <= OFS_DRVHEAD;

    ////////////////////////////////////////////////////////////////
    // Task-file registers
    assign lba28 = {20'h0_0000, dh_r[3:0], hi_c, mid_c, lo_c};
    assign lba48 = {hi_p, mid_p, lo_p, hi_c, mid_c, lo_c};
    assign ld_err = ack_err;

    tf_byte_store u_cnt (.aclk(aclk), .aresetn(aresetn), .wr_en(we_cnt), .wr_data(wb),
        .ld_en(1'b0), .ld_hi(1'b0), .ld_cur(BYTE_RESET), .ld_prev(BYTE_RESET),
        .cur_r(cnt_c), .prev_r(cnt_p));
    tf_byte_store u_lo (.aclk(aclk), .aresetn(aresetn), .wr_en(we_lo), .wr_data(wb),
        .ld_en(ld_err), .ld_hi(ext_r), .ld_cur(lba_r[7:0]), .ld_prev(lba_r[31:24]),
        .cur_r(lo_c), .prev_r(lo_p));
    tf_byte_store u_mid (.aclk(aclk), .aresetn(aresetn), .wr_en(we_mid), .wr_data(wb),
        .ld_en(ld_err), .ld_hi(ext_r), .ld_cur(lba_r[15:8]), .ld_prev(lba_r[39:32]),
        .cur_r(mid_c), .prev_r(mid_p));
    tf_byte_store u_hi (.aclk(aclk), .aresetn(aresetn), .wr_en(we_hi), .wr_data(wb),
        .ld_en(ld_err), .ld_hi(ext_r), .ld_cur(lba_r[23:16]), .ld_prev(lba_r[47:40]),
        .cur_r(hi_c), .prev_r(hi_p));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dh_r <= DH_RESET;
            feature_r <= BYTE_RESET;
        end else begin
            if (ld_err && !ext_r) begin
                dh_r[3:0] <= lba_r[27:24];
            end else if (tf_wr && awaddr_r == OFS_DRVHEAD) begin
                dh_r <= wb;
            end
            if (tf_wr && awaddr_r == OFS_FEATURE) begin
                feature_r <= wb;
            end
        end
    end

    // Reads of count through drive/head and task-file writes to other registers drop the high-order select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            devctl_r <= BYTE_RESET;
        end else if (do_wr && wstrb_r[0] && awaddr_r == OFS_DEVCTL) begin
            devctl_r <= wb;
        end else if (tf_rd || (tf_wr && awaddr_r != OFS_DEVCTL)) begin
            devctl_r[DC_HOB] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register read path
    assign busy = state_r == S_BUSY || state_r == S_PROG;
    assign data_request_flag = state_r == S_XFER || state_r == S_SOUT;

    always_comb begin
        rd_mux = '0;
        rresp_nxt = RESP_OKAY;
        case (s_axi_araddr)
            OFS_DATA: rd_mux = state_r == S_SOUT ? smart_word : 32'h0000_0000;
            // high half only with select set
            OFS_COUNT: rd_mux[7:0] = devctl_r[DC_HOB] ? cnt_p : cnt_c;
            OFS_ADDR_LO: rd_mux[7:0] = devctl_r[DC_HOB] ? lo_p : lo_c;
            OFS_ADDR_MID: rd_mux[7:0] = devctl_r[DC_HOB] ? mid_p : mid_c;
            OFS_ADDR_HI: rd_mux[7:0] = devctl_r[DC_HOB] ? hi_p : hi_c;
            OFS_DRVHEAD: rd_mux[7:0] = dh_r;
            OFS_CMD: begin
                rd_mux[ST_BUSY] = busy;
                rd_mux[ST_SMART] = smart_en_r;
                rd_mux[ST_DRQ] = data_request_flag;
                rd_mux[ST_ERR] = |error_r;
            end
            OFS_DEVCTL: rd_mux[7:0] = devctl_r;
            OFS_ERROR: rd_mux[7:0] = error_r;
            OFS_FEATURE: rd_mux = '0;
            default: rresp_nxt = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rresp_nxt;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command decode
    assign accept = we_cmd;
    assign acc_wr = accept && (wb == OP_WRITE || wb == OP_WRITE_EXT || wb == OP_WRITE_VFY);
    assign acc_smart = accept && wb == OP_SMART;
    assign smart_ok = feature_r == FT_READ_DATA || feature_r == FT_READ_THR
        || feature_r == FT_STATUS || feature_r == FT_AUTOSAVE
        || feature_r == FT_ENABLE || feature_r == FT_DISABLE;
    assign last_word = word_r == 7'(SECTOR_WORDS - 1);
    assign sect_done = we_data && last_word;
    assign ack_ok = state_r == S_PROG && media_ack && !media_err;
    assign ack_err = state_r == S_PROG && media_ack && media_err;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= S_IDLE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (acc_wr || (acc_smart && (feature_r == FT_READ_DATA || feature_r == FT_READ_THR))) begin
                        state_r <= S_BUSY;
                    end
                end
                S_BUSY: state_r <= smart_rd_r ? S_SOUT : S_XFER;
                S_XFER: if (sect_done) state_r <= S_PROG;
                S_PROG: begin
                    if (ack_err || (ack_ok && remain_r == 17'h0_0001)) begin
                        state_r <= S_IDLE;
                    end else if (ack_ok) begin
                        state_r <= S_XFER;
                    end
                end
                S_SOUT: if (rd_data && smart_index_r == 7'(SECTOR_WORDS - 1)) state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Transfer address and count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lba_r <= '0;
            remain_r <= '0;
            ext_r <= 1'b0;
            smart_rd_r <= 1'b0;
            media_req_r <= '0;
        end else if (accept) begin
            // 48-bit field built from both writes
            ext_r <= wb == OP_WRITE_EXT;
            media_req_r.verify <= wb == OP_WRITE_VFY;
            smart_rd_r <= acc_smart;
            if (wb == OP_WRITE_EXT) begin
                lba_r <= lba48;
                remain_r <= {cnt_p, cnt_c} == 16'h0000 ? CNT48_ZERO : {1'b0, cnt_p, cnt_c};
            end else begin
                lba_r <= lba28;
                remain_r <= cnt_c == 8'h00 ? CNT28_ZERO : {9'h000, cnt_c};
            end
        end else if (ack_ok) begin
            lba_r <= lba_r + 48'h0000_0000_0001;
            remain_r <= remain_r - 17'h0_0001;
        end
        if (aresetn && sect_done) begin
            media_req_r.lba <= lba_r;
        end
    end

    // Media handshake and data words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            media_req_valid_r <= 1'b0;
            media_wvalid_r <= 1'b0;
            media_wdata_r <= '0;
            word_r <= '0;
        end else begin
            media_wvalid_r <= we_data;
            if (we_data) begin
                media_wdata_r <= wdata_r;
                word_r <= word_r + 7'h01;
            end
            if (sect_done) begin
                media_req_valid_r <= 1'b1;
            end else if (media_ack) begin
                media_req_valid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Health monitoring state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_r <= 1'b0;
            smart_en_r <= 1'b0;
        end else if (!init_r) begin
            init_r <= 1'b1;
            smart_en_r <= smart_en_nv;
        end else if (acc_smart && feature_r == FT_ENABLE) begin
            smart_en_r <= 1'b1;
        end else if (acc_smart && feature_r == FT_DISABLE) begin
            smart_en_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smart_index_r <= '0;
        end else if (state_r == S_BUSY) begin
            smart_index_r <= '0;
        end else if (rd_data) begin
            smart_index_r <= smart_index_r + 7'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_r <= BYTE_RESET;
        end else if (ack_err) begin
            error_r[ER_MEDIA] <= 1'b1;
        end else if (accept) begin
            error_r <= BYTE_RESET;
            error_r[ER_ABRT] <= !(acc_wr || (acc_smart && smart_ok));
        end
    end

    ////////////////////////////////////////////////////////////////
    // Host interrupt, set wins over the status-read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_intrq_r <= 1'b0;
        end else if (ack_ok || ack_err) begin
            host_intrq_r <= 1'b1;
        end else if (accept && !acc_wr && !(state_r == S_IDLE && smart_rd_next())) begin
            host_intrq_r <= 1'b1;
        end else if (state_r == S_BUSY && smart_rd_r) begin
            host_intrq_r <= 1'b1;
        end else if (rd_st || accept) begin
            host_intrq_r <= 1'b0;
        end
    end

    function automatic logic smart_rd_next();
        smart_rd_next = acc_smart && (feature_r == FT_READ_DATA || feature_r == FT_READ_THR);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Checks
    chk_accept_seq: assert property (@(posedge aclk) disable iff (!aresetn)
        acc_wr |=> busy && !data_request_flag ##1 data_request_flag && !busy)
        else $error("write accept not busy then request");
    chk_no_first_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        acc_wr |=> !host_intrq_r [*2])
        else $error("interrupt before first sector");
    chk_count_28: assert property (@(posedge aclk) disable iff (!aresetn)
        acc_wr && wb != OP_WRITE_EXT && cnt_c == 8'h00 |=> remain_r == 17'h0_0100)
        else $error("zero count not 256");
    chk_count_48: assert property (@(posedge aclk) disable iff (!aresetn)
        acc_wr && wb == OP_WRITE_EXT && {cnt_p, cnt_c} == 16'h0000 |=> remain_r == 17'h1_0000)
        else $error("zero count not 65536");
    chk_sector_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        sect_done |=> busy && !data_request_flag && media_req_valid_r)
        else $error("full sector not busy");
    chk_next_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_ok && remain_r > 17'h0_0001 |=> data_request_flag && host_intrq_r && lba_r == $past(lba_r) + 48'h1)
        else $error("next block not announced");
    chk_done_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_ok && remain_r == 17'h0_0001 |=> !busy && !data_request_flag && host_intrq_r)
        else $error("completion not announced");
    chk_err_addr: assert property (@(posedge aclk) disable iff (!aresetn)
        ack_err |=> lo_c == $past(lba_r[7:0]) && hi_c == $past(lba_r[23:16]) && state_r == S_IDLE)
        else $error("failing address not reported");
    chk_smart_abort: assert property (@(posedge aclk) disable iff (!aresetn)
        acc_smart && !smart_ok |=> error_r[ER_ABRT] && state_r == S_IDLE)
        else $error("bad feature not aborted");
    cov_write_ext: cover property (@(posedge aclk) disable iff (!aresetn)
        acc_wr && wb == OP_WRITE_EXT ##[1:1000] ack_ok);
    cov_write_err: cover property (@(posedge aclk) disable iff (!aresetn) ack_err);
    cov_smart_read: cover property (@(posedge aclk) disable iff (!aresetn)
        state_r == S_SOUT ##1 state_r == S_IDLE);
endmodule

// ==== design/ata_wr_pkg.sv ====
// Constants and types shared by the sector write command block
package ata_wr_pkg;
    localparam int ADDR_W = 6;
    localparam int SECTOR_WORDS = 128;
    // Register byte offsets
    localparam logic [5:0] OFS_DATA = 6'h00;
    localparam logic [5:0] OFS_FEATURE = 6'h04;
    localparam logic [5:0] OFS_COUNT = 6'h08;
    localparam logic [5:0] OFS_ADDR_LO = 6'h0C;
    localparam logic [5:0] OFS_ADDR_MID = 6'h10;
    localparam logic [5:0] OFS_ADDR_HI = 6'h14;
    localparam logic [5:0] OFS_DRVHEAD = 6'h18;
    localparam logic [5:0] OFS_CMD = 6'h1C;
    localparam logic [5:0] OFS_DEVCTL = 6'h20;
    localparam logic [5:0] OFS_ERROR = 6'h24;
    // Status, control and error bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_SMART = 5;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int DC_HOB = 7;
    localparam int ER_MEDIA = 6;
    localparam int ER_ABRT = 2;
    // Opcodes and health-monitoring features
    localparam logic [7:0] OP_WRITE = 8'h30;
    localparam logic [7:0] OP_WRITE_EXT = 8'h34;
    localparam logic [7:0] OP_WRITE_VFY = 8'h3C;
    localparam logic [7:0] OP_SMART = 8'hB0;
    localparam logic [7:0] FT_READ_DATA = 8'hD0;
    localparam logic [7:0] FT_READ_THR = 8'hD1;
    localparam logic [7:0] FT_AUTOSAVE = 8'hD2;
    localparam logic [7:0] FT_ENABLE = 8'hD8;
    localparam logic [7:0] FT_DISABLE = 8'hD9;
    localparam logic [7:0] FT_STATUS = 8'hDA;
    // Counts and reset values
    localparam logic [16:0] CNT28_ZERO = 17'h0_0100;
    localparam logic [16:0] CNT48_ZERO = 17'h1_0000;
    localparam logic [7:0] DH_RESET = 8'hA0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_BUSY = 3'b001,
        S_XFER = 3'b011,
        S_PROG = 3'b010,
        S_SOUT = 3'b110
    } cmd_state_t;

    typedef struct packed {
        logic [47:0] lba;
        logic verify;
    } media_req_t;
endpackage

// ==== design/tf_byte_store.sv ====
// Two-deep task-file byte store with error write-back
`timescale 1ns/10ps
module tf_byte_store
    import ata_wr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic ld_en,
    input wire logic ld_hi,
    input wire logic [7:0] ld_cur,
    input wire logic [7:0] ld_prev,
    output logic [7:0] cur_r,
    output logic [7:0] prev_r
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_r <= BYTE_RESET;
            prev_r <= BYTE_RESET;
        end else if (ld_en) begin
            cur_r <= ld_cur;
            if (ld_hi) begin
                prev_r <= ld_prev;
            end
        end else if (wr_en) begin
            prev_r <= cur_r;
            cur_r <= wr_data;
        end
    end
endmodule

// ==== verif/ata_sector_write_and_smart_decode_test.sv ====
// Self-checking bench for the sector write and health command block
`timescale 1ns/10ps
module ata_sector_write_and_smart_decode_test;
    import ata_wr_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, fail = 0, smart_en_nv = 1, en_x = 1;
    logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, smart_word = 0, s_axi_rdata, rd_d, media_wdata_r;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_intrq_r;
    logic media_req_valid_r, media_ack, media_err, media_wvalid_r, smart_en_r;
    logic [6:0] smart_index_r;
    logic [47:0] lba, f;
    logic [7:0] ft [7];
    media_req_t media_req_r;
    int num_errors = 0, check_count = 0, cycles = 0;
    logic [31:0] sent [$], q [$];
    always #20 aclk = ~aclk;
    ata_sector_write u_ata_sector_write (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .host_intrq_r, .media_req_r, .media_req_valid_r, .media_ack,
        .media_err, .media_wdata_r, .media_wvalid_r, .smart_word, .smart_index_r, .smart_en_nv, .smart_en_r);
    media_model u_media_model (.aclk, .aresetn, .req_valid(media_req_valid_r), .fail, .ack(media_ack),
        .err(media_err));
    always @(posedge aclk) begin
        if (media_wvalid_r) sent.push_back(media_wdata_r);
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task end_of_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function logic [7:0] st(input logic b, input logic d, input logic e);
        return {b, 1'b0, en_x, 1'b0, d, 2'b00, e};
    endfunction
    task wr(input logic [5:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 0;
        dd = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
                ad = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wready && !dd) begin
                dd = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        rd_r = s_axi_bresp;
    endtask
    task rd(input logic [5:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
    endtask
    task setup(input logic [15:0] n, input logic [47:0] a, input logic [7:0] dh, input logic [7:0] ftr,
        input logic [7:0] op);
        wr(OFS_FEATURE, 32'(ftr));
        wr(OFS_COUNT, 32'(n[15:8]));
        wr(OFS_COUNT, 32'(n[7:0]));
        for (int i = 0; i < 3; i++) begin
            wr(6'(OFS_ADDR_LO + 4 * i), 32'(a[24 + 8 * i +: 8]));
            wr(6'(OFS_ADDR_LO + 4 * i), 32'(a[8 * i +: 8]));
        end
        wr(OFS_DRVHEAD, 32'(dh));
        wr(OFS_CMD, 32'(op));
    endtask
    task sectors(input int n, input int fail_at, input logic [47:0] a, input logic vfy);
        repeat (3) @(posedge aclk);
        chk(host_intrq_r, 0);
        rd(OFS_CMD);
        chk(rd_d[7:0], st(0, 1, 0));
        // host moves data only once busy has cleared
        for (int s = 0; s < n; s++) begin
            sent.delete();
            q.delete();
            fail <= (s == fail_at);
            for (int w = 0; w < SECTOR_WORDS; w++) begin
                q.push_back($urandom);
                wr(OFS_DATA, q[w]);
            end
            while (!media_req_valid_r) @(posedge aclk);
            // Last word reaches the capture queue one edge later
            @(posedge aclk);
            foreach (q[i]) chk(sent[i], q[i]);
            chk(media_req_r.lba, a + 48'(s));
            chk(media_req_r.verify, vfy);
            while (!host_intrq_r) @(posedge aclk);
            rd(OFS_CMD);
            if (s == fail_at) begin
                chk(rd_d[7:0], st(0, 0, 1));
                break;
            end
            chk(rd_d[7:0], st(0, s < n - 1, 0));
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hd442));
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(OFS_CMD);
        chk(rd_d[7:0], st(0, 0, 0));
        rd(6'h28);
        chk(rd_r, RESP_SLVERR);
        wr(6'h28, 32'h0000_0000);
        chk(rd_r, RESP_SLVERR);
        $display("test reset done");
        lba = 48'($urandom) & 48'h0FFF_FFFF;
        setup(16'h0002, lba, {4'hE, lba[27:24]}, 8'h00, OP_WRITE);
        sectors(2, 9, lba, 0);
        $display("test write done");
        for (int k = 0; k < 2; k++) begin
            lba = k ? {$urandom, 16'($urandom)} : 48'($urandom) & 48'h0FFF_FFFF;
            f = lba + 48'h1;
            setup(16'h0000, lba, k ? 8'hE0 : {4'hE, lba[27:24]}, 8'h00, k ? OP_WRITE_EXT : OP_WRITE_VFY);
            sectors(k ? 65536 : 256, 1, lba, !k);
            rd(OFS_ERROR);
            chk(rd_d[ER_MEDIA], 1);
            for (int i = 0; i < 3; i++) begin
                if (k) wr(OFS_DEVCTL, 32'h0000_0080);
                if (k) rd(6'(OFS_ADDR_LO + 4 * i));
                if (k) chk(rd_d[7:0], f[24 + 8 * i +: 8]);
                rd(6'(OFS_ADDR_LO + 4 * i));
                chk(rd_d[7:0], f[8 * i +: 8]);
            end
            rd(OFS_DRVHEAD);
            if (!k) chk(rd_d[3:0], f[27:24]);
            $display("test long write %0d done", k);
        end
        ft = '{FT_READ_DATA, FT_READ_THR, FT_AUTOSAVE, FT_ENABLE, FT_DISABLE, FT_STATUS, 8'h00};
        do ft[6] = 8'($urandom); while (ft[6] inside {[8'hD0 : 8'hD2], [8'hD8 : 8'hDA]});
        for (int i = 0; i < 7; i++) begin
            smart_word <= $urandom;
            setup(16'h0000, 48'h0000_00C2_4F00, 8'hE0, ft[i], OP_SMART);
            while (!host_intrq_r) @(posedge aclk);
            if (i < 2) for (int j = 0; j < SECTOR_WORDS; j++) begin
                chk(smart_index_r, 48'(j));
                rd(OFS_DATA);
                chk(rd_d, smart_word);
            end
            en_x = (i == 3) ? 1'b1 : (i == 4) ? 1'b0 : en_x;
            chk(smart_en_r, en_x);
            rd(OFS_CMD);
            chk(rd_d[7:0], st(0, 0, i == 6));
            rd(OFS_ERROR);
            chk(rd_d[ER_ABRT], i == 6);
        end
        wr(OFS_CMD, 32'h0000_00EE);
        chk(rd_r, RESP_OKAY);
        chk(host_intrq_r, 1);
        rd(OFS_ERROR);
        chk(rd_d[ER_ABRT], 1);
        $display("test health done");
        end_of_test();
    end
endmodule

// ==== verif/media_model.sv ====
// Media side partner: acknowledges each sector request after a random wait
`timescale 1ns/10ps
module media_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_valid,
    input wire logic fail,
    output logic ack,
    output logic err
);
    logic [2:0] wait_r;
    logic done_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            ack <= 1'b0;
            err <= 1'b0;
            wait_r <= 3'h1;
            done_r <= 1'b0;
        end else begin
            ack <= 1'b0;
            // Error line means nothing outside the ack pulse
            err <= 1'($urandom);
            if (!req_valid) begin
                done_r <= 1'b0;
                wait_r <= 3'($urandom_range(1, 6));
            end else if (!done_r) begin
                if (wait_r == 3'h0) begin
                    ack <= 1'b1;
                    err <= fail;
                    done_r <= 1'b1;
                end else begin
                    wait_r <= wait_r - 3'h1;
                end
            end
        end
    end
endmodule
